//--- hdl/gsc_cmd_map.sv
`timescale 1ns/1ps
`default_nettype none
module gsc_cmd_map #(
  parameter logic [6:0] DEV_ADDR        = 7'h55, // Arbitrary bus address
  parameter int         FLASH_BLK_BYTES = 32
) (
  // Clock and reset
  input  wire logic                            mclk,
  input  wire logic                            rst_n,
  // Host two-wire pins
  input  wire logic                            scl_in,
  input  wire logic                            sda_in,
  output logic                                 sda_out,
  output logic                                 sda_oe_n,
  // Gauge core results and events
  input  wire logic                            core_update,
  input  wire logic [gsc_pkg::STD_SLOTS*16-1:0] core_results,
  input  wire logic [15:0]                     core_ctl_resp,
  input  wire logic                            core_unlock,
  input  wire logic                            core_bat_present,
  input  wire logic                            core_low_current,
  input  wire logic                            core_soc_alert,
  // Host requests towards the gauge core
  output logic                                 ctrl_strobe,
  output logic [15:0]                          ctrl_word,
  output logic [15:0]                          at_rate,
  output logic                                 host_wr_strobe,
  output logic [4:0]                           host_wr_index,
  output logic [15:0]                          host_wr_data,
  // Mode and alert
  output logic                                 locked_access_mode,
  output var gsc_pkg::gsc_pmode_t              power_mode,
  output logic                                 soc_int
);

  localparam int FLASH_BYTES = FLASH_BLK_BYTES * gsc_pkg::FLASH_BLKS;
  localparam int FA_W        = $clog2(FLASH_BYTES);

  // Block offset must fit the code window below the next region
  if (FLASH_BLK_BYTES < 2 || FLASH_BLK_BYTES > 32 ||
      $countones(FLASH_BLK_BYTES) != 1)
  begin : g_chk
    $error("FLASH_BLK_BYTES must be a power of two from 2 to 32");
  end

  // Location decode used by both read and write paths
  function automatic logic slot_mapped(input logic [4:0] s);
    slot_mapped = (s < 5'(gsc_pkg::STD_SLOTS)) && (s != gsc_pkg::GAP_SLOT);
  endfunction

  function automatic logic slot_writable(input logic [4:0] s, input logic lk);
    slot_writable = !lk || (s <= gsc_pkg::AT_RATE_SLOT);
  endfunction

  // Pin synchronisers and bus conditions
  logic [1:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       scl_d;
  logic       sda_d;

  gsc_sync2 #(.W(2)) u_pin_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     ({scl_in, sda_in}),
    .q     (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  wire start_cond = scl_s && scl_d && sda_d && !sda_s;
  wire stop_cond  = scl_s && scl_d && !sda_d && sda_s;
  wire scl_rise   = scl_s && !scl_d;
  wire scl_fall   = !scl_s && scl_d;

  // Byte engine state
  gsc_pkg::gsc_i2c_t state_reg;
  gsc_pkg::gsc_i2c_t state_next;
  logic [3:0]        cnt_reg;
  logic [7:0]        shreg_reg;
  logic [7:0]        txsh_reg;
  logic [7:0]        ptr_reg;
  logic              rw_reg;

  wire byte_end = scl_fall && (cnt_reg == gsc_pkg::CNT_BYTE);
  wire addr_hit = shreg_reg[7:1] == DEV_ADDR;
  wire in_ack   = (state_reg == gsc_pkg::I2C_ACK_A) || (state_reg == gsc_pkg::I2C_ACK_C) ||
                  (state_reg == gsc_pkg::I2C_ACK_W) || (state_reg == gsc_pkg::I2C_RACK);
  wire tx_load  = scl_fall && ((state_reg == gsc_pkg::I2C_ACK_A && rw_reg) ||
                  (state_reg == gsc_pkg::I2C_RACK && cnt_reg == 4'h1));

  // Code first, data after; a repeated start keeps the code for reads
  always_comb
  begin
    state_next = state_reg;
    if (stop_cond)
      state_next = gsc_pkg::I2C_IDLE;
    else if (start_cond)
      state_next = gsc_pkg::I2C_ADDR;
    else
      unique case (state_reg)
        gsc_pkg::I2C_IDLE: ;
        gsc_pkg::I2C_ADDR:
          if (byte_end)
            state_next = addr_hit ? gsc_pkg::I2C_ACK_A : gsc_pkg::I2C_IDLE;
        gsc_pkg::I2C_ACK_A:
          if (scl_fall)
            state_next = rw_reg ? gsc_pkg::I2C_RDAT : gsc_pkg::I2C_CMD;
        gsc_pkg::I2C_CMD:
          if (byte_end)
            state_next = gsc_pkg::I2C_ACK_C;
        gsc_pkg::I2C_ACK_C:
          if (scl_fall)
            state_next = gsc_pkg::I2C_WDAT;
        gsc_pkg::I2C_WDAT:
          if (byte_end)
            state_next = gsc_pkg::I2C_ACK_W;
        gsc_pkg::I2C_ACK_W:
          if (scl_fall)
            state_next = gsc_pkg::I2C_WDAT;
        gsc_pkg::I2C_RDAT:
          if (byte_end)
            state_next = gsc_pkg::I2C_RACK;
        gsc_pkg::I2C_RACK:
          if (scl_rise && sda_s)
            state_next = gsc_pkg::I2C_IDLE;
          else if (tx_load)
            state_next = gsc_pkg::I2C_RDAT;
      endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= gsc_pkg::I2C_IDLE;
    else
      state_reg <= state_next;
  end

  // Bit counter and receive shifter
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg   <= 4'h0;
      shreg_reg <= 8'h00;
    end
    else if (start_cond || stop_cond)
      cnt_reg <= 4'h0;
    else if (scl_rise && cnt_reg != gsc_pkg::CNT_BYTE)
    begin
      cnt_reg   <= cnt_reg + 4'h1;
      shreg_reg <= {shreg_reg[6:0], sda_s};
    end
    else if (scl_fall && (cnt_reg == gsc_pkg::CNT_BYTE || in_ack))
      cnt_reg <= 4'h0;
  end

  // Register file storage
  logic [15:0] word_reg [gsc_pkg::STD_SLOTS];
  logic [7:0]  flash_mem [FLASH_BYTES];
  logic        blk_sel_reg;
  logic [7:0]  lo_buf_reg;
  logic        lo_ok_reg;
  logic [7:0]  hi_snap_reg;
  logic        snap_ok_reg;
  logic        sel_status_reg;
  logic        hib_reg;
  logic        snz_reg;
  logic [15:0] ctl_status;

  // Address decode of the current code pointer
  wire [4:0]       slot     = ptr_reg[5:1];
  wire             in_std   = ptr_reg < gsc_pkg::CMD_STD_END;
  wire             std_ok   = in_std && slot_mapped(slot);
  wire [7:0]       fl_off   = ptr_reg - gsc_pkg::CMD_FLASH_BASE;
  wire             in_flash = (ptr_reg >= gsc_pkg::CMD_FLASH_BASE) &&
                              (fl_off < 8'(FLASH_BLK_BYTES));
  wire [FA_W-1:0]  fl_addr  = {blk_sel_reg, fl_off[FA_W-2:0]};
  wire [15:0]      ctl_read = sel_status_reg ? ctl_status : core_ctl_resp;
  wire [15:0]      std_word = !std_ok ? gsc_pkg::WORD_RST :
                              (slot == gsc_pkg::CTRL_SLOT) ? ctl_read : word_reg[slot];

  // Write decode: even byte is parked, odd byte completes the word
  wire        wr_byte  = (state_reg == gsc_pkg::I2C_WDAT) && byte_end;
  wire        wr_lo    = wr_byte && std_ok && !ptr_reg[0];
  wire        commit   = wr_byte && std_ok && ptr_reg[0] &&
                         slot_writable(slot, locked_access_mode);
  wire [15:0] cm_data  = {shreg_reg, lo_ok_reg ? lo_buf_reg : std_word[7:0]};
  wire        ctl_wr   = commit && (slot == gsc_pkg::CTRL_SLOT);
  wire        fl_wr    = wr_byte && in_flash;
  wire        blk_wr   = wr_byte && (ptr_reg == gsc_pkg::CMD_BLK_SEL);

  // Read byte mux; results pass through in core units
  wire [7:0] std_byte = ptr_reg[0] ? (snap_ok_reg ? hi_snap_reg : std_word[15:8])
                                   : std_word[7:0];
  wire [7:0] rd_byte  = in_std ? std_byte :
                        (ptr_reg == gsc_pkg::CMD_BLK_SEL) ? {7'h00, blk_sel_reg} :
                        in_flash ? flash_mem[fl_addr] : 8'h00;

  // Pointer, direction and transmit shifter; pointer spools per byte
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ptr_reg  <= 8'h00;
      rw_reg   <= 1'b0;
      txsh_reg <= 8'h00;
    end
    else
    begin
      if (state_reg == gsc_pkg::I2C_ADDR && byte_end)
        rw_reg <= shreg_reg[0];
      if (state_reg == gsc_pkg::I2C_CMD && byte_end)
        ptr_reg <= shreg_reg;
      else if (wr_byte || tx_load)
        ptr_reg <= ptr_reg + 8'h01;
      if (tx_load)
        txsh_reg <= rd_byte;
      else if (state_reg == gsc_pkg::I2C_RDAT && scl_fall)
        txsh_reg <= {txsh_reg[6:0], 1'b0};
    end
  end

  // Open-drain data pin; enable low pulls the line low
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      sda_oe_n <= 1'b1;
    else if (start_cond || stop_cond)
      sda_oe_n <= 1'b1;
    else if (tx_load)
      sda_oe_n <= rd_byte[7];
    else if (byte_end && (state_reg == gsc_pkg::I2C_CMD ||
             state_reg == gsc_pkg::I2C_WDAT ||
             (state_reg == gsc_pkg::I2C_ADDR && addr_hit)))
      sda_oe_n <= 1'b0;
    else if (state_reg == gsc_pkg::I2C_RDAT && scl_fall)
      sda_oe_n <= byte_end ? 1'b1 : txsh_reg[6];
    else if (in_ack && scl_fall)
      sda_oe_n <= 1'b1;
  end

  assign sda_out = 1'b0;

  // Word pairing: low byte parked, high byte snapshot for a coherent read
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lo_buf_reg  <= 8'h00;
      lo_ok_reg   <= 1'b0;
      hi_snap_reg <= 8'h00;
      snap_ok_reg <= 1'b0;
    end
    else
    begin
      if (start_cond || commit)
        lo_ok_reg <= 1'b0;
      else if (wr_lo)
        lo_ok_reg <= 1'b1;
      if (wr_lo)
        lo_buf_reg <= shreg_reg;
      if (start_cond)
        snap_ok_reg <= 1'b0;
      else if (tx_load)
        snap_ok_reg <= std_ok && !ptr_reg[0];
      if (tx_load)
        hi_snap_reg <= std_word[15:8];
    end
  end

  // Result words: host write wins over a core refresh in the same cycle
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < gsc_pkg::STD_SLOTS; i++)
        word_reg[i] <= gsc_pkg::WORD_RST;
    end
    else
    begin
      for (int i = 1; i < gsc_pkg::STD_SLOTS; i++)
      begin
        if (commit && slot == 5'(i))
          word_reg[i] <= cm_data;
        else if (core_update && i > 1 && slot_mapped(5'(i)))
          word_reg[i] <= core_results[i*16 +: 16];
      end
    end
  end

  assign at_rate = word_reg[gsc_pkg::AT_RATE_SLOT];

  // User flash bytes; no reset, storage only
  always_ff @(posedge mclk)
  begin
    if (fl_wr)
      flash_mem[fl_addr] <= shreg_reg;
  end

  // Status word seen at the control location
  always_comb
  begin
    ctl_status = gsc_pkg::WORD_RST;
    ctl_status[gsc_pkg::STS_LOCKED_BIT] = locked_access_mode;
    ctl_status[gsc_pkg::STS_HIB_BIT]    = hib_reg;
    ctl_status[gsc_pkg::STS_SNZ_BIT]    = snz_reg;
    ctl_status[gsc_pkg::STS_SLEEP_BIT]  = power_mode == gsc_pkg::PM_SLEEP;
  end

  // Control subcommands; lock request wins over a same-cycle unlock
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      locked_access_mode <= gsc_pkg::LOCK_RST;
      sel_status_reg     <= 1'b1;
      hib_reg            <= 1'b0;
      snz_reg            <= 1'b0;
      blk_sel_reg        <= 1'b0;
    end
    else
    begin
      if (ctl_wr && cm_data == gsc_pkg::SUB_LOCK)
        locked_access_mode <= 1'b1;
      else if (core_unlock)
        locked_access_mode <= 1'b0;
      if (ctl_wr)
        sel_status_reg <= cm_data == gsc_pkg::SUB_STATUS;
      if (ctl_wr && cm_data == gsc_pkg::SUB_SET_HIB)
        hib_reg <= 1'b1;
      else if (ctl_wr && cm_data == gsc_pkg::SUB_CLR_HIB)
        hib_reg <= 1'b0;
      if (ctl_wr && cm_data == gsc_pkg::SUB_SET_SNZ)
        snz_reg <= 1'b1;
      else if (ctl_wr && cm_data == gsc_pkg::SUB_CLR_SNZ)
        snz_reg <= 1'b0;
      if (blk_wr)
        blk_sel_reg <= shreg_reg[0];
    end
  end

  // Requests handed to the gauge core, one pulse per committed word
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_strobe    <= 1'b0;
      ctrl_word      <= gsc_pkg::WORD_RST;
      host_wr_strobe <= 1'b0;
      host_wr_index  <= 5'h00;
      host_wr_data   <= gsc_pkg::WORD_RST;
      soc_int        <= 1'b0;
    end
    else
    begin
      ctrl_strobe    <= ctl_wr;
      host_wr_strobe <= commit && !ctl_wr;
      soc_int        <= core_soc_alert;
      if (ctl_wr)
        ctrl_word <= cm_data;
      if (commit && !ctl_wr)
      begin
        host_wr_index <= slot;
        host_wr_data  <= cm_data;
      end
    end
  end

  // Power modes; with the pack present any start condition wakes to normal so the map stays reachable
  gsc_power u_power (
    .mclk          (mclk),
    .rst_n         (rst_n),
    .bat_present   (core_bat_present),
    .low_current   (core_low_current),
    .host_activity (start_cond),
    .hib_req       (hib_reg),
    .snooze_en     (snz_reg),
    .power_mode    (power_mode)
  );

endmodule
`default_nettype wire

//--- hdl/gsc_pkg.sv
`default_nettype none
// Shared constants for the gauge standard command map
package gsc_pkg;

  // Standard locations: one 16-bit word per even/odd code pair
  localparam int STD_SLOTS = 25;
  localparam logic [4:0] CTRL_SLOT    = 5'h00;
  localparam logic [4:0] AT_RATE_SLOT = 5'h01;
  localparam logic [4:0] GAP_SLOT     = 5'h15;

  // Command code of each standard location (low byte; high byte is code + 1)
  // Units: current mA, voltage mV, temp 0.1 K, charge mAh, time min,
  // energy mWh, power mW, charge and health percent
  localparam logic [7:0]
    OFS_HOST_CONTROL_WORD   = 8'h00, OFS_RATE_PROBE_CURRENT = 8'h02,
    OFS_RATE_PROBE_RUNTIME  = 8'h04, OFS_THERMAL_READING    = 8'h06,
    OFS_CELL_POTENTIAL      = 8'h08, OFS_GAUGE_STATUS_BITS  = 8'h0A,
    OFS_NOMINAL_CHARGE_LEFT = 8'h0C, OFS_FULL_AVAIL_CHARGE  = 8'h0E,
    OFS_REMAINING_CHARGE    = 8'h10, OFS_FULL_CHARGE_CAP    = 8'h12,
    OFS_MEAN_CURRENT        = 8'h14, OFS_RUNTIME_TO_EMPTY   = 8'h16,
    OFS_RUNTIME_TO_FULL     = 8'h18, OFS_STANDBY_CURRENT    = 8'h1A,
    OFS_STANDBY_RUNTIME     = 8'h1C, OFS_MAX_LOAD_CURRENT   = 8'h1E,
    OFS_MAX_LOAD_RUNTIME    = 8'h20, OFS_ENERGY_LEFT        = 8'h22,
    OFS_MEAN_POWER          = 8'h24, OFS_CONST_POWER_RUNTIME = 8'h26,
    OFS_HEALTH_PERCENT      = 8'h28, OFS_CHARGE_PERCENT     = 8'h2C,
    OFS_IMPEDANCE_CAL       = 8'h2E, OFS_INSTANT_CURRENT    = 8'h30;
  localparam logic [7:0] CMD_STD_END    = 8'h32;

  // Extended codes reaching the two user flash blocks
  localparam logic [7:0] CMD_BLK_SEL    = 8'h3E;
  localparam logic [7:0] CMD_FLASH_BASE = 8'h40;
  localparam int         FLASH_BLKS     = 2;

  // Control subcommands handled here
  localparam logic [15:0] SUB_STATUS  = 16'h0000;
  localparam logic [15:0] SUB_SET_HIB = 16'h0011;
  localparam logic [15:0] SUB_CLR_HIB = 16'h0012;
  localparam logic [15:0] SUB_SET_SNZ = 16'h0013;
  localparam logic [15:0] SUB_CLR_SNZ = 16'h0014;
  localparam logic [15:0] SUB_LOCK    = 16'h0020;

  // Status word bit positions
  localparam int STS_LOCKED_BIT = 13;
  localparam int STS_HIB_BIT    = 6;
  localparam int STS_SNZ_BIT    = 5;
  localparam int STS_SLEEP_BIT  = 4;

  // Values after reset, and the bit count of one byte
  localparam logic        LOCK_RST = 1'b0;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [3:0]  CNT_BYTE = 4'h8;

  typedef enum logic [3:0] {
    I2C_IDLE, I2C_ADDR, I2C_ACK_A, I2C_CMD, I2C_ACK_C,
    I2C_WDAT, I2C_ACK_W, I2C_RDAT, I2C_RACK
  } gsc_i2c_t;

  typedef enum logic [2:0] {
    PM_NORMAL, PM_SLEEP, PM_DEEP, PM_HIB, PM_PACK_DETECT
  } gsc_pmode_t;

  localparam gsc_pmode_t PMODE_RST = PM_PACK_DETECT;

endpackage
`default_nettype wire

//--- hdl/gsc_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module gsc_sync2 #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // Asynchronous in, synchronous out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // Two stages; idle bus level is high
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '1;
      q        <= '1;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule
`default_nettype wire

//--- hdl/gsc_power.sv
`timescale 1ns/1ps
`default_nettype none
module gsc_power (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Events
  input  wire logic       bat_present,
  input  wire logic       low_current,
  input  wire logic       host_activity,
  input  wire logic       hib_req,
  input  wire logic       snooze_en,
  // Mode
  output var gsc_pkg::gsc_pmode_t power_mode
);

  gsc_pkg::gsc_pmode_t mode_next;

  // Event driven mode walk; host bits steer sleep depth
  always_comb
  begin
    mode_next = power_mode;
    if (!bat_present)
      mode_next = gsc_pkg::PM_PACK_DETECT;
    else
      unique case (power_mode)
        gsc_pkg::PM_NORMAL:
          if (low_current && !host_activity)
            mode_next = gsc_pkg::PM_SLEEP;
        gsc_pkg::PM_SLEEP:
          if (!low_current || host_activity)
            mode_next = gsc_pkg::PM_NORMAL;
          else if (hib_req)
            mode_next = gsc_pkg::PM_HIB;
          else if (snooze_en)
            mode_next = gsc_pkg::PM_DEEP;
        gsc_pkg::PM_DEEP:
          if (!low_current || host_activity || !snooze_en)
            mode_next = gsc_pkg::PM_NORMAL;
        gsc_pkg::PM_HIB:
          if (host_activity || !hib_req)
            mode_next = gsc_pkg::PM_NORMAL;
        gsc_pkg::PM_PACK_DETECT:
          mode_next = gsc_pkg::PM_NORMAL;
      endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      power_mode <= gsc_pkg::PMODE_RST;
    else
      power_mode <= mode_next;
  end

endmodule
`default_nettype wire

//--- test/gsc_cmd_map_chk.sv
`timescale 1ns/1ps
`default_nettype none
module gsc_cmd_map_chk (
  // Clock and reset
  input wire logic                mclk,
  input wire logic                rst_n,
  // Core side
  input wire logic                core_unlock,
  input wire logic                core_bat_present,
  input wire logic                core_soc_alert,
  // Host requests and state
  input wire logic                ctrl_strobe,
  input wire logic [15:0]         ctrl_word,
  input wire logic [15:0]         at_rate,
  input wire logic                host_wr_strobe,
  input wire logic [4:0]          host_wr_index,
  input wire logic [15:0]         host_wr_data,
  input wire logic                locked_access_mode,
  input wire gsc_pkg::gsc_pmode_t power_mode,
  input wire logic                soc_int
);
  // One domain only
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  property p_soc;
    $past(rst_n) |-> soc_int == $past(core_soc_alert);
  endproperty
  a_soc: assert property (p_soc) else $error("alert not mirrored");
  property p_pack;
    !core_bat_present |-> ##[1:2] power_mode == gsc_pkg::PM_PACK_DETECT;
  endproperty
  a_pack: assert property (p_pack) else $error("no pack detect");
  property p_rel;
    core_bat_present && power_mode == gsc_pkg::PM_PACK_DETECT |=> power_mode == gsc_pkg::PM_NORMAL;
  endproperty
  a_rel: assert property (p_rel) else $error("no return to normal");
  property p_unlock;
    // A lock written in the same cycle wins over the unlock
    core_unlock |=> !locked_access_mode || ctrl_strobe && ctrl_word == gsc_pkg::SUB_LOCK;
  endproperty
  a_unlock: assert property (p_unlock) else $error("still locked");
  property p_lock;
    ctrl_strobe && ctrl_word == gsc_pkg::SUB_LOCK |-> ##[0:2] locked_access_mode;
  endproperty
  a_lock: assert property (p_lock) else $error("lock not taken");
  // Once locked only the at-rate word may reach the core on the host write port
  property p_wr_lock;
    host_wr_strobe && locked_access_mode && $past(locked_access_mode)
      |-> host_wr_index == gsc_pkg::AT_RATE_SLOT;
  endproperty
  a_wr_lock: assert property (p_wr_lock) else $error("write while locked");
  property p_gap;
    host_wr_strobe |-> host_wr_index != gsc_pkg::GAP_SLOT && host_wr_index != 5'h00
      && host_wr_index < 5'h19;
  endproperty
  a_gap: assert property (p_gap) else $error("bad write index");
  property p_atrate;
    host_wr_strobe && host_wr_index == gsc_pkg::AT_RATE_SLOT |-> ##[0:2] at_rate == host_wr_data;
  endproperty
  a_atrate: assert property (p_atrate) else $error("at rate not loaded");
endmodule
bind gsc_cmd_map gsc_cmd_map_chk u_chk (.*);
`default_nettype wire

//--- test/gsc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module gsc_host_model (
  // Clock
  input  wire logic mclk,
  // Two-wire bus
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // Clock stands high and data is released while idle
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Start or repeated start: data falls while clock high
  task automatic start();
    sda_low <= 1'b0;
    tick(6);
    scl <= 1'b1;
    tick(12);
    sda_low <= 1'b1;
    tick(12);
    scl <= 1'b0;
    tick(4);
  endtask
  // Stop: data rises while clock high
  task automatic stop();
    sda_low <= 1'b1;
    tick(6);
    scl <= 1'b1;
    tick(12);
    sda_low <= 1'b0;
    tick(30);
  endtask
  // Data held 4 cycles past the fall, so it never moves under a high clock
  task automatic bit_io(input logic b, output logic r);
    sda_low <= !b;
    tick(8);
    scl <= 1'b1;
    tick(12);
    r = sda;
    scl <= 1'b0;
    tick(4);
  endtask
  task automatic byte_io(input logic [7:0] d, input logic nine, output logic [7:0] q,
                         output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(nine, ack);
  endtask
endmodule
`default_nettype wire

//--- test/gsc_cmd_map_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gsc_cmd_map_tb;
  logic                             mclk, rst_n, scl, sda_low, sda_out, sda_oe_n;
  logic                             core_update, core_unlock, core_bat_present;
  logic                             core_low_current, core_soc_alert, soc_int;
  logic                             ctrl_strobe, host_wr_strobe, locked_access_mode;
  logic [gsc_pkg::STD_SLOTS*16-1:0] core_results;
  logic [15:0]                      core_ctl_resp, ctrl_word, at_rate, host_wr_data, w;
  logic [4:0]                       host_wr_index;
  logic [7:0]                       q;
  logic                             a;
  gsc_pkg::gsc_pmode_t              power_mode;
  int                               bad_count, total_checks;
  wire                              sda;
  // Pull-up wire: low when either side pulls
  assign sda = !(sda_low || (!sda_oe_n && !sda_out));
  // Code, written word, word read back
  logic [39:0] rows [5] = '{{8'h02, 16'h1234, 16'h1234}, {8'h30, 16'hBEEF, 16'hBEEF},
    {8'h08, 16'h0F0A, 16'h0F0A}, {8'h2A, 16'h5555, 16'h0000}, {8'h32, 16'h7777, 16'h0000}};

  gsc_cmd_map dut (.*, .scl_in(scl), .sda_in(sda));
  gsc_host_model host (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_mode(input string n, input gsc_pkg::gsc_pmode_t e);
    total_checks++;
    if (power_mode !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %0d seen %0d", n, e, power_mode);
    end
  endtask
  // Bounded wait for a power mode; giving up ends the run
  task automatic wait_mode(input gsc_pkg::gsc_pmode_t m);
    for (int n = 0; n < 400 && power_mode !== m; n++) @(posedge mclk);
    chk_mode("mode", m);
    if (power_mode !== m) end_of_test();
  endtask
  // Code byte then both data bytes, low byte first
  task automatic wr_word(input logic [7:0] c, input logic [15:0] d);
    logic [7:0] b [4];
    logic       nk;
    b = '{8'hAA, c, d[7:0], d[15:8]};
    nk = 1'b0;
    host.start();
    // Every byte's acknowledge is folded in, not just the last one
    foreach (b[i])
    begin
      host.byte_io(b[i], 1'b1, q, a);
      nk = nk | a;
    end
    host.stop();
    chk("write ack", 16'h0000, {15'h0000, nk});
  endtask
  task automatic rd_word(input logic [7:0] c, output logic [15:0] d);
    host.start();
    host.byte_io(8'hAA, 1'b1, q, a);
    host.byte_io(c, 1'b1, q, a);
    host.start();
    host.byte_io(8'hAB, 1'b1, q, a);
    host.byte_io(8'hFF, 1'b0, d[7:0], a);
    host.byte_io(8'hFF, 1'b1, d[15:8], a);
    host.stop();
  endtask
  task automatic pulse_update();
    @(posedge mclk);
    core_update <= 1'b1;
    @(posedge mclk);
    core_update <= 1'b0;
  endtask

  initial
  begin
    rst_n = 1'b0;
    {core_update, core_unlock, core_low_current, core_soc_alert} = 4'h0;
    core_bat_present = 1'b1;
    core_results = '0;
    core_ctl_resp = 16'h5A5A;
    bad_count = 0;
    total_checks = 0;
    repeat (20) @(posedge mclk);
    chk_mode("reset mode", gsc_pkg::PM_PACK_DETECT);
    chk("reset release", 16'h0001, {15'h0000, sda_oe_n});
    rst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    chk_mode("awake", gsc_pkg::PM_NORMAL);
    chk("lock reset", 16'h0000, {15'h0000, locked_access_mode});
    rd_word(8'h00, w);
    chk("status", 16'h0000, w);
    // Open mode: every location takes writes, unused codes read zero
    foreach (rows[i])
    begin
      wr_word(rows[i][39:32], rows[i][31:16]);
      rd_word(rows[i][39:32], w);
      chk("row word", rows[i][15:0], w);
    end
    wr_word(8'h00, 16'h0001);
    rd_word(8'h00, w);
    chk("ctl resp", 16'h5A5A, w);
    wr_word(8'h00, 16'h0013);
    wr_word(8'h00, 16'h0000);
    rd_word(8'h00, w);
    chk("snooze bit", 16'h0020, w);
    // Slot i loads A500 plus i
    for (int i = 0; i < 25; i++) core_results[i*16+:16] <= 16'hA500 | i[15:0];
    pulse_update();
    rd_word(8'h06, w);
    chk("result word", 16'hA503, w);
    rd_word(8'h30, w);
    chk("last slot", 16'hA518, w);
    rd_word(8'h2A, w);
    chk("gap", 16'h0000, w);
    // Locked: results read-only, at-rate still writable
    wr_word(8'h00, 16'h0020);
    chk("locked", 16'h0001, {15'h0000, locked_access_mode});
    wr_word(8'h08, 16'h1111);
    rd_word(8'h08, w);
    chk("read only", 16'hA504, w);
    wr_word(8'h02, 16'h4321);
    rd_word(8'h02, w);
    chk("at rate", 16'h4321, w);
    chk("at rate port", 16'h4321, at_rate);
    wr_word(8'h3E, 16'h0001);
    wr_word(8'h5E, 16'hCAFE);
    rd_word(8'h5E, w);
    chk("user block", 16'hCAFE, w);
    @(posedge mclk);
    core_unlock <= 1'b1;
    @(posedge mclk);
    core_unlock <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("unlocked", 16'h0000, {15'h0000, locked_access_mode});
    host.start();
    host.byte_io(8'h22, 1'b1, q, a);
    host.stop();
    chk("foreign nack", 16'h0001, {15'h0000, a});
    core_soc_alert <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("alert", 16'h0001, {15'h0000, soc_int});
    // Snooze set: low current leads on to deep sleep
    core_low_current <= 1'b1;
    wait_mode(gsc_pkg::PM_DEEP);
    wr_word(8'h00, 16'h0011);
    wr_word(8'h00, 16'h0000);
    wait_mode(gsc_pkg::PM_HIB);
    rd_word(8'h00, w);
    chk("hib bit", 16'h0060, w);
    // Hibernate and snooze cleared: low current parks in sleep
    wr_word(8'h00, 16'h0012);
    wr_word(8'h00, 16'h0014);
    wr_word(8'h00, 16'h0000);
    rd_word(8'h00, w);
    chk("sleep bit", 16'h0010, w);
    core_low_current <= 1'b0;
    wait_mode(gsc_pkg::PM_NORMAL);
    core_bat_present <= 1'b0;
    wait_mode(gsc_pkg::PM_PACK_DETECT);
    core_bat_present <= 1'b1;
    wait_mode(gsc_pkg::PM_NORMAL);
    // Second reset in mid-run clears the host words
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    rd_word(8'h02, w);
    chk("at rate reset", 16'h0000, w);
    end_of_test();
  end
endmodule
`default_nettype wire
